// ---- sarseq_map.svh ----
// register map, field positions, reset values and timing counts of the converter sequencer
`ifndef SARSEQ_MAP_SVH
`define SARSEQ_MAP_SVH

// ----------------------------------------------------------------
// register indexes (byte address is four times the index)
// ----------------------------------------------------------------
`define SARSEQ_IDX_PIN_SEL   6'h08
`define SARSEQ_IDX_CTRL      6'h09
`define SARSEQ_IDX_RES_MAIN  6'h0b
`define SARSEQ_IDX_RES_HIGH  6'h0c
`define SARSEQ_IDX_RES_LOW   6'h0d
`define SARSEQ_IDX_EVT_STAT  6'h0e
`define SARSEQ_IDX_IRQ_MASK  6'h0f

// ----------------------------------------------------------------
// converter_control fields
// ----------------------------------------------------------------
`define SARSEQ_CTRL_REF      7
`define SARSEQ_CTRL_RATE_HI  6
`define SARSEQ_CTRL_RATE_LO  5
`define SARSEQ_CTRL_RUN      4
`define SARSEQ_CTRL_PWR      3
`define SARSEQ_CTRL_CHAN_HI  1
`define SARSEQ_CTRL_CHAN_LO  0

// ----------------------------------------------------------------
// event status and mask fields
// ----------------------------------------------------------------
`define SARSEQ_STAT_DONE     0
`define SARSEQ_STAT_WAKE     1
`define SARSEQ_MASK_IRQ      0

// ----------------------------------------------------------------
// reset values and constants
// ----------------------------------------------------------------
`define SARSEQ_RST_PIN_SEL   4'h0
`define SARSEQ_RST_CTRL      8'h00
`define SARSEQ_RES_W         12
`define SARSEQ_VECTOR        12'h00c
`define SARSEQ_RATE_DIV16    2'h0
`define SARSEQ_RATE_DIV4     2'h1
`define SARSEQ_RATE_DIV64    2'h2
`define SARSEQ_RATE_RC       2'h3

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SARSEQ_CLK_PERIOD_NS 20
`define SARSEQ_BIT_TIME_NS   4000
`define SARSEQ_RC_BIT_NS     71000
`define SARSEQ_BIT_CYC       (`SARSEQ_BIT_TIME_NS / `SARSEQ_CLK_PERIOD_NS)
`define SARSEQ_SAMPLE_PER    4'h2
`define SARSEQ_CONV_PER      15

`endif

// ---- sarseq_pkg.sv ----
// types shared by the converter sequencer modules
package sarseq_pkg;
   typedef enum logic [1:0] {
      SARSEQ_IDLE,
      SARSEQ_SAMPLE,
      SARSEQ_CONV,
      SARSEQ_FINISH
   } sarseq_state_type;
endpackage

// ---- sarseq_clkdiv.sv ----
// bit-conversion clock enable: prescaled system clock or synchronised rc oscillator
`timescale 1ns/1ns
`include "sarseq_map.svh"
module sarseq_clkdiv (
   // clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // control
   input  wire logic       run,
   input  wire logic [1:0] rate,
   // rc oscillator pin
   input  wire logic       rc_osc_in,
   // enable out
   output logic            tick
);
   logic [5:0] cnt_r, cnt_nxt;
   logic       rc_s1_r, rc_s2_r, rc_s3_r;
   logic       tick_r, tick_nxt;

   // ----------------------------------------------------------------
   // divider
   // ----------------------------------------------------------------
   always_comb begin
      cnt_nxt  = run ? cnt_r + 6'h01 : 6'h00;
      tick_nxt = 1'b0;
      unique case (rate)
         `SARSEQ_RATE_DIV16: tick_nxt = run && (cnt_r[3:0] == 4'hf);
         `SARSEQ_RATE_DIV4:  tick_nxt = run && (cnt_r[1:0] == 2'h3);
         `SARSEQ_RATE_DIV64: tick_nxt = run && (cnt_r == 6'h3f);
         `SARSEQ_RATE_RC:    tick_nxt = run && rc_s2_r && !rc_s3_r;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r   <= 6'h00;
         rc_s1_r <= 1'b0;
         rc_s2_r <= 1'b0;
         rc_s3_r <= 1'b0;
         tick_r  <= 1'b0;
      end else begin
         cnt_r   <= cnt_nxt;
         rc_s1_r <= rc_osc_in;
         rc_s2_r <= rc_s1_r;
         rc_s3_r <= rc_s2_r;
         tick_r  <= tick_nxt;
      end
   end

   assign tick = tick_r;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_div4_spacing: assert property (
      @(posedge pclk) disable iff (!presetn)
      tick_r && rate == `SARSEQ_RATE_DIV4 && run ##1 $stable(rate) && run
      |-> !tick_r ##1 !tick_r ##1 !tick_r ##1 tick_r)
      else $error("divide-by-4 tick spacing wrong");
endmodule // sarseq_clkdiv

// ---- sarseq_top.sv ----
// successive-approximation converter sequencer with apb registers and wake logic
//
// Operation
// - on completion load results, clear run bit, set completion flag
// - clock-rate code 00 /16, 01 /4, 10 /64, 11 rc oscillator
// - bits paced by conversion clock; conversion lasts 15 bit periods
// - sleep does not abort a running conversion
// - in sleep the oscillator, timers and converter keep clocking
// - completion in sleep with wake enable wakes the device
// - irq enable without global enable wakes core to next instruction
// - irq enable and global enable in sleep wake and vector to 0x00c
// - awake with both enables, completion vectors to 0x00c
// - in sleep without irq enable converter powered off after completion
// - accepted channel change clears all result registers
// - run bit set by software only; only completion clears it
// - channel field changes only while flag and run are low
// - result has 12 bits by successive approximation
`timescale 1ns/1ns
`include "sarseq_map.svh"
module sarseq_top (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   // core status
   input  wire logic        sleep_mode,
   input  wire logic        global_irq_en,
   // core requests
   output logic             core_wake,
   output logic             irq_vector_req,
   output logic [11:0]      irq_vector,
   // analog front end
   input  wire logic        cmp_in,
   input  wire logic        rc_osc_in,
   output logic             adc_power,
   output logic             sample_en,
   output logic [11:0]      sar_code,
   output logic [1:0]       input_channel_sel,
   output logic             reference_source_sel,
   output logic [3:0]       pin_analog_enable
);
   sarseq_pkg::sarseq_state_type state_r, state_nxt;
   logic [3:0]  pin_en_r, pin_en_nxt;
   logic        ref_r, ref_nxt, run_r, run_nxt, pwr_r, pwr_nxt;
   logic [1:0]  rate_r, rate_nxt, chan_r, chan_nxt;
   logic        conv_done_flag_r, flag_nxt, conv_wake_enable_r, wake_en_nxt;
   logic        conv_irq_enable_r, irq_en_nxt;
   logic [11:0] res_r, res_nxt, trial_r, trial_nxt;
   logic [3:0]  bit_r, bit_nxt;
   logic        sleep_off_r, sleep_off_nxt, wake_r, wake_nxt, vec_r, vec_nxt;
   logic        pready_r, pready_nxt, pslverr_r, pslverr_nxt;
   logic [31:0] prdata_r, prdata_nxt;
   logic        cmp_s1_r, cmp_s2_r, tick, done_evt, wr_en, hit;
   logic [5:0]  idx;

   function automatic logic [5:0] word_idx(input logic [7:0] a);
      return a[7:2];
   endfunction

   function automatic logic mapped(input logic [7:0] a);
      logic [5:0] i;
      i = word_idx(a);
      return (a[1:0] == 2'h0) &&
             (i == `SARSEQ_IDX_PIN_SEL || i == `SARSEQ_IDX_CTRL ||
              i == `SARSEQ_IDX_RES_MAIN || i == `SARSEQ_IDX_RES_HIGH ||
              i == `SARSEQ_IDX_RES_LOW || i == `SARSEQ_IDX_EVT_STAT ||
              i == `SARSEQ_IDX_IRQ_MASK);
   endfunction

   // ----------------------------------------------------------------
   // conversion clock
   // ----------------------------------------------------------------
   // free of any sleep term so conversion keeps clocking in sleep
   sarseq_clkdiv u_clkdiv (
      .pclk      (pclk),
      .presetn   (presetn),
      .run       (state_r != sarseq_pkg::SARSEQ_IDLE),
      .rate      (rate_r),
      .rc_osc_in (rc_osc_in),
      .tick      (tick)
   );

   assign idx      = word_idx(paddr);
   assign hit      = mapped(paddr);
   assign wr_en    = psel && penable && pready_r && pwrite && hit;
   assign done_evt = (state_r == sarseq_pkg::SARSEQ_FINISH) && tick;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      state_nxt     = state_r;
      pin_en_nxt    = pin_en_r;
      ref_nxt       = ref_r;
      rate_nxt      = rate_r;
      run_nxt       = run_r;
      pwr_nxt       = pwr_r;
      chan_nxt      = chan_r;
      flag_nxt      = conv_done_flag_r;
      wake_en_nxt   = conv_wake_enable_r;
      irq_en_nxt    = conv_irq_enable_r;
      res_nxt       = res_r;
      trial_nxt     = trial_r;
      bit_nxt       = bit_r;
      sleep_off_nxt = sleep_off_r && sleep_mode;
      wake_nxt      = 1'b0;
      vec_nxt       = 1'b0;
      pready_nxt    = psel && !penable;
      pslverr_nxt   = psel && !penable && !hit;
      prdata_nxt    = prdata_r;

      // sequencer; no sleep term, so sleep never aborts it
      unique case (state_r)
         sarseq_pkg::SARSEQ_IDLE: begin
            if (run_r) begin
               state_nxt = sarseq_pkg::SARSEQ_SAMPLE;
               bit_nxt   = 4'h0;
               trial_nxt = 12'h800;
            end
         end
         sarseq_pkg::SARSEQ_SAMPLE: begin
            if (tick) begin
               bit_nxt = bit_r + 4'h1;
               if (bit_r == `SARSEQ_SAMPLE_PER - 4'h1) begin
                  state_nxt = sarseq_pkg::SARSEQ_CONV;
                  bit_nxt   = 4'hb;
               end
            end
         end
         sarseq_pkg::SARSEQ_CONV: begin
            if (tick) begin
               trial_nxt[bit_r] = cmp_s2_r;
               if (bit_r != 4'h0) begin
                  trial_nxt[bit_r - 4'h1] = 1'b1;
                  bit_nxt = bit_r - 4'h1;
               end else begin
                  state_nxt = sarseq_pkg::SARSEQ_FINISH;
               end
            end
         end
         sarseq_pkg::SARSEQ_FINISH: begin
            if (tick) begin
               state_nxt = sarseq_pkg::SARSEQ_IDLE;
               res_nxt   = trial_r;
               run_nxt   = 1'b0;
            end
         end
      endcase

      // completion side effects
      if (done_evt) begin
         if (sleep_mode && (conv_wake_enable_r || conv_irq_enable_r))
            wake_nxt = 1'b1;
         if (sleep_mode && !conv_irq_enable_r)
            sleep_off_nxt = 1'b1;
         if (conv_irq_enable_r && global_irq_en)
            vec_nxt = 1'b1;
      end

      // register writes
      if (wr_en) begin
         unique case (idx)
            `SARSEQ_IDX_PIN_SEL: pin_en_nxt = pwdata[3:0];
            `SARSEQ_IDX_CTRL: begin
               ref_nxt  = pwdata[`SARSEQ_CTRL_REF];
               rate_nxt = pwdata[`SARSEQ_CTRL_RATE_HI:`SARSEQ_CTRL_RATE_LO];
               pwr_nxt  = pwdata[`SARSEQ_CTRL_PWR];
               if (pwdata[`SARSEQ_CTRL_RUN])
                  run_nxt = 1'b1;
               if (!conv_done_flag_r && !run_r) begin
                  chan_nxt = pwdata[`SARSEQ_CTRL_CHAN_HI:`SARSEQ_CTRL_CHAN_LO];
                  if (chan_nxt != chan_r)
                     res_nxt = 12'h000;
               end
            end
            `SARSEQ_IDX_EVT_STAT: begin
               wake_en_nxt = pwdata[`SARSEQ_STAT_WAKE];
               if (!pwdata[`SARSEQ_STAT_DONE])
                  flag_nxt = 1'b0;
            end
            `SARSEQ_IDX_IRQ_MASK: irq_en_nxt = pwdata[`SARSEQ_MASK_IRQ];
            default: ;
         endcase
      end
      // set wins over a same-cycle clear; a new start leaves it alone
      if (done_evt)
         flag_nxt = 1'b1;

      // read data captured in the setup cycle
      if (psel && !penable && !pwrite) begin
         prdata_nxt = 32'h0000_0000;
         unique case (idx)
            `SARSEQ_IDX_PIN_SEL:  prdata_nxt[3:0] = pin_en_r;
            `SARSEQ_IDX_CTRL:     prdata_nxt[7:0] = {ref_r, rate_r, run_r, pwr_r, 1'b0, chan_r};
            `SARSEQ_IDX_RES_MAIN: prdata_nxt[7:0] = res_r[11:4];
            `SARSEQ_IDX_RES_HIGH: prdata_nxt[3:0] = res_r[11:8];
            `SARSEQ_IDX_RES_LOW:  prdata_nxt[7:0] = res_r[7:0];
            `SARSEQ_IDX_EVT_STAT: prdata_nxt[1:0] = {conv_wake_enable_r, conv_done_flag_r};
            `SARSEQ_IDX_IRQ_MASK: prdata_nxt[0]   = conv_irq_enable_r;
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r            <= sarseq_pkg::SARSEQ_IDLE;
         pin_en_r           <= `SARSEQ_RST_PIN_SEL;
         ref_r              <= 1'b0;
         rate_r             <= `SARSEQ_RATE_DIV16;
         run_r              <= 1'b0;
         pwr_r              <= 1'b0;
         chan_r             <= 2'h0;
         conv_done_flag_r   <= 1'b0;
         conv_wake_enable_r <= 1'b0;
         conv_irq_enable_r  <= 1'b0;
         res_r              <= 12'h000;
         trial_r            <= 12'h000;
         bit_r              <= 4'h0;
         sleep_off_r        <= 1'b0;
         wake_r             <= 1'b0;
         vec_r              <= 1'b0;
         pready_r           <= 1'b0;
         pslverr_r          <= 1'b0;
         prdata_r           <= 32'h0000_0000;
         cmp_s1_r           <= 1'b0;
         cmp_s2_r           <= 1'b0;
      end else begin
         state_r            <= state_nxt;
         pin_en_r           <= pin_en_nxt;
         ref_r              <= ref_nxt;
         rate_r             <= rate_nxt;
         run_r              <= run_nxt;
         pwr_r              <= pwr_nxt;
         chan_r             <= chan_nxt;
         conv_done_flag_r   <= flag_nxt;
         conv_wake_enable_r <= wake_en_nxt;
         conv_irq_enable_r  <= irq_en_nxt;
         res_r              <= res_nxt;
         trial_r            <= trial_nxt;
         bit_r              <= bit_nxt;
         sleep_off_r        <= sleep_off_nxt;
         wake_r             <= wake_nxt;
         vec_r              <= vec_nxt;
         pready_r           <= pready_nxt;
         pslverr_r          <= pslverr_nxt;
         prdata_r           <= prdata_nxt;
         cmp_s1_r           <= cmp_in;
         cmp_s2_r           <= cmp_s1_r;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   logic sample_r, power_r;
   logic [11:0] vector_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sample_r <= 1'b0;
         power_r  <= 1'b0;
         vector_r <= 12'h000;
      end else begin
         sample_r <= state_nxt == sarseq_pkg::SARSEQ_SAMPLE;
         power_r  <= pwr_nxt && !sleep_off_nxt;
         vector_r <= `SARSEQ_VECTOR;
      end
   end

   assign pready               = pready_r;
   assign prdata               = prdata_r;
   assign pslverr              = pslverr_r;
   assign core_wake            = wake_r;
   assign irq_vector_req       = vec_r;
   assign irq_vector           = vector_r;
   assign adc_power            = power_r;
   assign sample_en            = sample_r;
   assign sar_code             = trial_r;
   assign input_channel_sel    = chan_r;
   assign reference_source_sel = ref_r;
   assign pin_analog_enable    = pin_en_r;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   logic [4:0] tick_cnt_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         tick_cnt_r <= 5'h00;
      else if (state_r == sarseq_pkg::SARSEQ_IDLE)
         tick_cnt_r <= 5'h00;
      else if (tick)
         tick_cnt_r <= tick_cnt_r + 5'h01;
   end
   logic ctrl_run_wr, stat_clr_wr;
   assign ctrl_run_wr = wr_en && idx == `SARSEQ_IDX_CTRL && pwdata[`SARSEQ_CTRL_RUN];
   assign stat_clr_wr = wr_en && idx == `SARSEQ_IDX_EVT_STAT && !pwdata[`SARSEQ_STAT_DONE];

   a_done_effects: assert property (done_evt && !ctrl_run_wr |=>
      !run_r && conv_done_flag_r && res_r == $past(trial_r))
      else $error("completion effects missing");
   a_conv_length: assert property (done_evt |->
      tick_cnt_r == 5'(`SARSEQ_CONV_PER - 1))
      else $error("conversion not 15 bit periods");
   a_sleep_keeps: assert property (
      state_r == sarseq_pkg::SARSEQ_CONV && sleep_mode && !tick |=>
      state_r == sarseq_pkg::SARSEQ_CONV)
      else $error("sleep disturbed conversion");
   a_wake_sleep: assert property (
      done_evt && sleep_mode && conv_wake_enable_r |=> core_wake ##1 !core_wake)
      else $error("no wake pulse");
   a_resume_next: assert property (
      done_evt && sleep_mode && conv_irq_enable_r && !global_irq_en |=>
      core_wake && !irq_vector_req)
      else $error("wrong resume");
   a_vector_jump: assert property (
      done_evt && conv_irq_enable_r && global_irq_en |=>
      irq_vector_req && irq_vector == `SARSEQ_VECTOR)
      else $error("vector request missing");
   a_power_cut: assert property (
      done_evt && sleep_mode && !conv_irq_enable_r ##1 sleep_mode |=> !adc_power)
      else $error("converter still powered");
   a_chan_clear: assert property (
      wr_en && idx == `SARSEQ_IDX_CTRL && !conv_done_flag_r && !run_r && !done_evt &&
      pwdata[1:0] != chan_r |=> res_r == 12'h000)
      else $error("results not cleared");
   a_run_sticky: assert property (run_r && !done_evt |=> run_r)
      else $error("run bit cleared early");
   a_chan_lock: assert property (conv_done_flag_r || run_r |=> $stable(chan_r))
      else $error("channel changed while busy");
   a_flag_hold: assert property (
      conv_done_flag_r && !stat_clr_wr |=> conv_done_flag_r)
      else $error("flag lost");

   c_sleep_vector: cover property (done_evt && sleep_mode && global_irq_en ##1 irq_vector_req);
   c_awake_done: cover property (done_evt && !sleep_mode);
   c_rc_conv: cover property (done_evt && rate_r == `SARSEQ_RATE_RC);
   c_chan_clear: cover property (res_r != 12'h000 ##1 res_r == 12'h000);
endmodule // sarseq_top

// ---- sarseq_analog_model.sv ----
// behavioural comparator and rc oscillator facing the converter sequencer
`timescale 1ns/1ns
module sarseq_analog_model #(
   parameter int RC_HALF_NS = 203
) (
   // clock
   input  wire logic        pclk,
   // analog input and trial code
   input  wire logic [11:0] vin,
   input  wire logic [11:0] sar_code,
   input  wire logic        adc_power,
   // comparator and oscillator pins
   output logic             cmp_in,
   output logic             rc_osc_in
);
   logic osc  = 1'b0;
   logic junk = 1'b0;

   // free-running oscillator, phase unrelated to pclk
   always #(RC_HALF_NS) osc = ~osc;
   always @(posedge pclk) junk <= ~junk;

   assign rc_osc_in = osc;
   // unpowered comparator gives no steady answer
   assign cmp_in = adc_power ? (vin >= sar_code) : junk;
endmodule // sarseq_analog_model

// ---- sarseq_top_test.sv ----
// self-checking bench of the converter sequencer
`timescale 1ns/1ns
`include "sarseq_map.svh"
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin fail_count++; \
   $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module sarseq_top_test;
   localparam int RC_HALF = 203;
   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic        sleep_mode = 1'b0, global_irq_en = 1'b0, err;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, pslverr, core_wake, irq_vector_req, cmp_in, rc_osc_in;
   logic        adc_power, sample_en, reference_source_sel;
   logic [11:0] irq_vector, sar_code, vin = 12'h000;
   logic [1:0]  input_channel_sel;
   logic [3:0]  pin_analog_enable;
   logic [31:0] seed = 32'd93449;
   logic [3:0]  modes [8] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h3, 4'hc, 4'ha, 4'hb};
   int          fail_count = 0, checks = 0, cyc = 0, wake_n = 0, vec_n = 0;

   sarseq_top DUT (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .sleep_mode(sleep_mode), .global_irq_en(global_irq_en), .core_wake(core_wake),
      .irq_vector_req(irq_vector_req), .irq_vector(irq_vector), .cmp_in(cmp_in),
      .rc_osc_in(rc_osc_in), .adc_power(adc_power), .sample_en(sample_en),
      .sar_code(sar_code), .input_channel_sel(input_channel_sel),
      .reference_source_sel(reference_source_sel), .pin_analog_enable(pin_analog_enable)
   );

   sarseq_analog_model #(.RC_HALF_NS(RC_HALF)) far_side (
      .pclk(pclk), .vin(vin), .sar_code(sar_code), .adc_power(adc_power),
      .cmp_in(cmp_in), .rc_osc_in(rc_osc_in)
   );

   always #10 pclk = ~pclk;

   always @(negedge pclk) begin
      wake_n += int'(core_wake === 1'b1);
      vec_n  += int'(irq_vector_req === 1'b1);
   end

   always @(posedge pclk) begin
      cyc++;
      if (cyc == 30000) begin
         fail_count++;
         print_verdict();
      end
   end
   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   task print_verdict;
      $display("checks=%0d fail_count=%0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic apb(input logic w, input logic [5:0] idx, input logic [7:0] wd);
      int k;
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= {idx, 2'b00};
      pwdata <= {24'h0, wd};
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      @(negedge pclk);
      while (pready !== 1'b1 && k < 20) begin
         @(negedge pclk);
         k++;
      end
      if (k == 20)
         fail_count++;
      rd  = prdata;
      err = pslverr;
      @(posedge pclk);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // m holds sleep, wake enable, irq enable, global enable
   task automatic conv(input logic [3:0] m, input logic [1:0] rt, input logic [11:0] v,
                       input logic [1:0] ch);
      int per, t0, w0, v0, n;
      per = (rt == 2'h0) ? 16 : (rt == 2'h1) ? 4 : (rt == 2'h2) ? 64 : 2 * RC_HALF / 20;
      vin <= v;
      apb(1'b1, `SARSEQ_IDX_IRQ_MASK, {7'h0, m[1]});
      apb(1'b1, `SARSEQ_IDX_EVT_STAT, {6'h0, m[2], 1'b0});
      global_irq_en <= m[0];
      apb(1'b1, `SARSEQ_IDX_CTRL, {v[0], rt, 2'b01, 1'b0, ch});
      @(negedge pclk);
      `CHK(input_channel_sel, ch)
      `CHK(reference_source_sel, v[0])
      repeat (130) @(posedge pclk);
      sleep_mode <= m[3];
      apb(1'b1, `SARSEQ_IDX_CTRL, {v[0], rt, 2'b11, 1'b0, ch});
      t0 = cyc;
      w0 = wake_n;
      v0 = vec_n;
      apb(1'b1, `SARSEQ_IDX_CTRL, {v[0], rt, 2'b01, 1'b0, ~ch});
      @(negedge pclk);
      `CHK(sample_en, 1'b1)
      apb(1'b0, `SARSEQ_IDX_CTRL, 8'h00);
      `CHK(rd[4], 1'b1)
      `CHK(input_channel_sel, ch)
      n = 0;
      // polling by register reads only, no port output while converting
      while (rd[4] !== 1'b0 && n < 400) begin
         apb(1'b0, `SARSEQ_IDX_CTRL, 8'h00);
         n++;
      end
      `CHK((cyc - t0 >= 14 * per) && (cyc - t0 <= 16 * per + 16), 1'b1)
      @(negedge pclk);
      `CHK(adc_power, ~(m[3] & ~m[1]))
      `CHK(sample_en, 1'b0)
      `CHK(sar_code, v)
      `CHK(wake_n - w0, int'(m[3] & (m[2] | m[1])))
      `CHK(vec_n - v0, int'(m[1] & m[0]))
      `CHK(irq_vector, 12'h00c)
      apb(1'b0, `SARSEQ_IDX_RES_MAIN, 8'h00);
      sleep_mode <= 1'b0;
      `CHK(rd, {24'h0, v[11:4]})
      apb(1'b0, `SARSEQ_IDX_RES_HIGH, 8'h00);
      `CHK(rd, {28'h0, v[11:8]})
      apb(1'b0, `SARSEQ_IDX_RES_LOW, 8'h00);
      `CHK(rd, {24'h0, v[7:0]})
      apb(1'b1, `SARSEQ_IDX_CTRL, {v[0], rt, 2'b01, 1'b0, ~ch});
      @(negedge pclk);
      `CHK(input_channel_sel, ch)
      apb(1'b0, `SARSEQ_IDX_EVT_STAT, 8'h00);
      `CHK(rd, {30'h0, m[2], 1'b1})
      apb(1'b1, `SARSEQ_IDX_EVT_STAT, {6'h0, m[2], 1'b0});
      apb(1'b0, `SARSEQ_IDX_EVT_STAT, 8'h00);
      `CHK(rd[0], 1'b0)
   endtask
   // ----------------------------------------------------------------
   // sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `SARSEQ_IDX_CTRL, 8'h00);
      `CHK(rd, 32'h0)
      `CHK(irq_vector, 12'h00c)
      apb(1'b0, `SARSEQ_IDX_PIN_SEL, 8'h00);
      `CHK(rd, 32'h0)
      apb(1'b0, 6'h00, 8'h00);
      `CHK({err, rd}, {1'b1, 32'h0})
      apb(1'b1, `SARSEQ_IDX_PIN_SEL, 8'h5a);
      apb(1'b0, `SARSEQ_IDX_PIN_SEL, 8'h00);
      `CHK(rd, 32'h0000000a)
      `CHK(pin_analog_enable, 4'ha)
      for (int i = 0; i < 8; i++) begin
         seed = xs(seed);
         conv(modes[i], 2'(i), (i == 0) ? 12'hfff : (i == 1) ? 12'h000 :
              (seed[11:0] | 12'h011), seed[13:12]);
      end
      // accepted channel change while idle
      apb(1'b1, `SARSEQ_IDX_CTRL, {6'b000010, ~seed[13:12]});
      @(negedge pclk);
      `CHK(input_channel_sel, ~seed[13:12])
      apb(1'b0, `SARSEQ_IDX_RES_MAIN, 8'h00);
      `CHK(rd, 32'h0)
      apb(1'b0, `SARSEQ_IDX_RES_LOW, 8'h00);
      `CHK(rd, 32'h0)
      print_verdict();
   end
endmodule // sarseq_top_test
